// [hdl/irsl_pkg.sv]
// package of constants, types and helpers for the infrared secondary link block
package irsl_pkg;

    localparam int unsigned CLK_HZ = 20_000_000;

    // buffering and framing
    localparam int unsigned BUF_DEPTH = 64;
    localparam int unsigned UART_FIFO_DEPTH = 2;
    localparam int unsigned FRAME_PAYLOAD = 64;
    localparam int unsigned FRAME_HDR = 6;
    localparam int unsigned FRAME_TRL = 2;
    localparam int unsigned FRAME_OVERHEAD = FRAME_HDR + FRAME_TRL;
    localparam int unsigned FRAME_TOTAL = FRAME_PAYLOAD + FRAME_OVERHEAD;

    // timing
    localparam int unsigned TURN_US = 1000;
    localparam int unsigned TURN_CYC = (CLK_HZ / 1_000_000) * TURN_US;
    localparam int unsigned LINK_TIMEOUT_S = 10;
    localparam int unsigned LINK_TIMEOUT_CYC = CLK_HZ * LINK_TIMEOUT_S;
    localparam int unsigned INIT_CYC = 16;

    // infrared rates
    localparam int unsigned IR_DEFAULT_BAUD = 9600;
    localparam int unsigned IR_MAX_BAUD = 115_200;
    localparam logic [2:0] RATE_DEFAULT = 3'h0;
    localparam logic [2:0] RATE_MAX = 3'h4;

    // discovery slot answered
    localparam logic [2:0] SLOT_RESP = 3'h2;

    // frame bytes
    localparam logic [7:0] HDR_BOF = 8'hc0;
    localparam logic [7:0] TRL_EOF = 8'hc1;
    localparam logic [7:0] TRL_FCS = 8'h00;
    localparam logic [7:0] HDR_PAD = 8'h00;
    localparam logic [7:0] LINK_ADDR = 8'h01;
    localparam int unsigned CTL_ACK_BIT = 0;
    localparam int unsigned CTL_CLOSE_BIT = 1;
    localparam int unsigned CTL_DISC_BIT = 2;

    // register map, byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_LEVEL = 8'h08;
    localparam logic [7:0] REG_ERR = 8'h0c;
    localparam int unsigned CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RST = 1'b1;
    localparam int unsigned ST_CONN_BIT = 0;
    localparam int unsigned ST_CTSN_BIT = 1;
    localparam int unsigned ST_DSR_BIT = 2;
    localparam int unsigned ST_RATE_LSB = 4;
    localparam int unsigned ST_STATE_LSB = 8;
    localparam int unsigned LVL_SER_LSB = 8;
    localparam int unsigned ERR_CRC_LSB = 8;
    localparam int unsigned ERR_NACK_LSB = 16;

    typedef enum logic [1:0] {
        KIND_DATA = 2'b00,
        KIND_CLOSE = 2'b01,
        KIND_DISC = 2'b10
    } irsl_kind_t;

    typedef enum logic [1:0] {
        RESP_DATA = 2'b00,
        RESP_CLOSE = 2'b01,
        RESP_DISC = 2'b10
    } irsl_resp_t;

    typedef enum logic [2:0] {
        ST_DISC = 3'b000,
        ST_CONN = 3'b001,
        ST_RX = 3'b010,
        ST_TURN = 3'b011,
        ST_TX = 3'b100
    } irsl_state_t;

    // one beat from the infrared decoder; crc_ok, kind, slot, peer_ack valid on eof
    typedef struct packed {
        logic sof;
        logic eof;
        logic has_data;
        logic crc_ok;
        logic peer_ack;
        irsl_kind_t kind;
        logic [2:0] slot;
        logic [7:0] data;
    } irsl_rx_t;

    // one byte to the infrared encoder
    typedef struct packed {
        logic sof;
        logic eof;
        logic [7:0] data;
    } irsl_tx_t;

    function automatic logic [15:0] irsl_ir_div(input logic [2:0] code);
        case (code)
            3'h0: irsl_ir_div = 16'(CLK_HZ / IR_DEFAULT_BAUD);
            3'h1: irsl_ir_div = 16'(CLK_HZ / 19_200);
            3'h2: irsl_ir_div = 16'(CLK_HZ / 38_400);
            3'h3: irsl_ir_div = 16'(CLK_HZ / 57_600);
            default: irsl_ir_div = 16'(CLK_HZ / IR_MAX_BAUD);
        endcase
    endfunction : irsl_ir_div

    function automatic logic [15:0] irsl_ser_div(input logic [1:0] code);
        case (code)
            2'h0: irsl_ser_div = 16'(CLK_HZ / 9600);
            2'h1: irsl_ser_div = 16'(CLK_HZ / 19_200);
            2'h2: irsl_ser_div = 16'(CLK_HZ / 57_600);
            default: irsl_ser_div = 16'(CLK_HZ / 115_200);
        endcase
    endfunction : irsl_ser_div

endpackage : irsl_pkg

// [hdl/irsl_fifo.sv]
// synchronous first-in first-out byte buffer with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module irsl_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 64,
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1,
    localparam int unsigned CW = $clog2(DEPTH + 1)
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [CW-1:0] count
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic push, pop;

    assign in_ready = (cnt_q != CW'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign count = cnt_q;

    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wr_d = wr_q;
        rd_d = rd_q;
        if (push) begin
            wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
        end
        if (pop) begin
            rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
        end
        cnt_d = cnt_q + CW'(push) - CW'(pop);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // storage carries no reset; only counted entries are ever read
    always_ff @(posedge hclk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

endmodule : irsl_fifo
`default_nettype wire

// [hdl/irsl_link.sv]
// connected-state link control of the infrared secondary, with its AHB-Lite registers
//
// The register addresses and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module irsl_link
    import irsl_pkg::*;
#(
    parameter int unsigned TURN_CYCLES = TURN_CYC,
    parameter int unsigned TIMEOUT_CYCLES = LINK_TIMEOUT_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic ir_rx_valid,
    input wire irsl_rx_t ir_rx,
    output logic ir_rx_ready,
    output logic ir_tx_valid,
    output irsl_tx_t ir_tx,
    input wire logic ir_tx_ready,
    input wire logic link_open,
    input wire logic [2:0] link_rate_sel,
    input wire logic ser_in_valid,
    input wire logic [7:0] ser_in_data,
    output logic host_out_valid,
    output logic [7:0] host_out_data,
    input wire logic host_out_ready,
    input wire logic [1:0] serial_rate_select_pins,
    output logic [15:0] ir_bit_div,
    output logic [15:0] serial_bit_div,
    output logic cts_n,
    output logic dsr,
    output logic carrier_detect
);
    localparam logic [15:0] TURN_LAST = 16'(TURN_CYCLES - 1);
    localparam logic [31:0] TO_LAST = 32'(TIMEOUT_CYCLES - 1);
    localparam int unsigned CW = $clog2(BUF_DEPTH + 1);

    ////////////////////////////////////////////////////////////////////////////
    // buffers
    logic ir_in_valid, ir_in_ready, uart_in_ready, uart_out_valid, uart_out_ready;
    logic ser_in_v, ser_buf_ready, ser_out_valid, ser_pop, fill_ok;
    logic [7:0] uart_out_data, ser_out_data;
    logic [CW-1:0] ir_count, ser_count;

    irsl_fifo #(.WIDTH(8), .DEPTH(BUF_DEPTH)) u_ir_buf (
        .hclk(hclk), .hresetn(hresetn),
        .in_valid(ir_in_valid), .in_ready(ir_in_ready), .in_data(ir_rx.data),
        .out_valid(host_out_valid), .out_ready(host_out_ready),
        .out_data(host_out_data), .count(ir_count)
    );

    // two-entry front fifo absorbs bytes the host sends after cts went inactive
    irsl_fifo #(.WIDTH(8), .DEPTH(UART_FIFO_DEPTH)) u_uart_fifo (
        .hclk(hclk), .hresetn(hresetn),
        .in_valid(ser_in_valid), .in_ready(uart_in_ready), .in_data(ser_in_data),
        .out_valid(uart_out_valid), .out_ready(uart_out_ready),
        .out_data(uart_out_data), .count()
    );

    irsl_fifo #(.WIDTH(8), .DEPTH(BUF_DEPTH)) u_ser_buf (
        .hclk(hclk), .hresetn(hresetn),
        .in_valid(ser_in_v), .in_ready(ser_buf_ready), .in_data(uart_out_data),
        .out_valid(ser_out_valid), .out_ready(ser_pop),
        .out_data(ser_out_data), .count(ser_count)
    );

    ////////////////////////////////////////////////////////////////////////////
    // link state
    irsl_state_t state_q, state_d;
    irsl_resp_t resp_q, resp_d;
    logic conn_q, conn_d, ack_q, ack_d, txv_q, txv_d, en_q, dsr_q, dsr_d;
    logic [15:0] turn_q, turn_d, irdiv_q, serdiv_q;
    logic [31:0] idle_q, idle_d;
    logic [2:0] rate_q, rate_d, rate_req;
    logic [6:0] len_q, len_d, idx_q, idx_d, total;
    logic [4:0] init_q, init_d;
    irsl_tx_t txb_q, txb_d;
    logic rx_take, crc_inc, nack_inc, drop_inc, load;

    // serial buffer only fills in plain connected idle, never mid-frame
    assign fill_ok = conn_q && (state_q == ST_CONN);
    assign ser_in_v = uart_out_valid && fill_ok;
    assign uart_out_ready = ser_buf_ready && fill_ok;
    assign drop_inc = ser_in_valid && !uart_in_ready;
    // cts is local: dsr up, link up, no infrared activity, serial buffer with room
    assign cts_n = !(dsr_q && fill_ok && ser_buf_ready);
    assign carrier_detect = conn_q;
    assign dsr = dsr_q;
    assign ir_tx_valid = txv_q;
    assign ir_tx = txb_q;
    assign ir_bit_div = irdiv_q;
    assign serial_bit_div = serdiv_q;
    assign ir_in_valid = rx_take && ir_rx.has_data && conn_q;
    // payload stalls the decoder when the infrared buffer is full
    assign ir_rx_ready = en_q && ((state_q == ST_DISC) || (state_q == ST_CONN)
        || (state_q == ST_RX)) && !(ir_rx.has_data && conn_q && !ir_in_ready);
    assign rx_take = ir_rx_valid && ir_rx_ready;
    assign rate_req = (link_rate_sel > RATE_MAX) ? RATE_MAX : link_rate_sel;
    assign total = 7'(FRAME_HDR + FRAME_TRL) + len_q;
    assign load = (state_q == ST_TX) && (!txv_q || ir_tx_ready) && (idx_q != total);
    assign ser_pop = load && (idx_q >= 7'(FRAME_HDR)) && (idx_q < total - 7'(FRAME_TRL));

    always_comb begin
        init_d = init_q;
        dsr_d = dsr_q;
        if (init_q != 5'(INIT_CYC)) begin
            init_d = init_q + 1'b1;
        end else begin
            dsr_d = 1'b1;
        end
    end

    always_comb begin
        state_d = state_q;
        conn_d = conn_q;
        resp_d = resp_q;
        ack_d = ack_q;
        turn_d = turn_q;
        idle_d = idle_q;
        rate_d = rate_q;
        len_d = len_q;
        idx_d = idx_q;
        txv_d = txv_q;
        txb_d = txb_q;
        crc_inc = 1'b0;
        nack_inc = 1'b0;
        if (conn_q && (idle_q != TO_LAST)) begin
            idle_d = idle_q + 1'b1;
        end
        if (txv_q && ir_tx_ready) begin
            txv_d = 1'b0;
        end
        case (state_q)
            ST_DISC, ST_CONN, ST_RX: begin
                if ((state_q == ST_DISC) && link_open && en_q) begin
                    conn_d = 1'b1;
                    rate_d = rate_req;
                    idle_d = '0;
                    state_d = ST_CONN;
                end else if (rx_take && ir_rx.eof) begin
                    state_d = ST_TURN;
                    turn_d = TURN_LAST;
                    ack_d = ir_rx.crc_ok;
                    crc_inc = !ir_rx.crc_ok;
                    if (conn_q) begin
                        idle_d = '0;
                        nack_inc = ir_rx.crc_ok && !ir_rx.peer_ack;
                        resp_d = (ir_rx.crc_ok && ir_rx.kind == KIND_CLOSE) ?
                            RESP_CLOSE : RESP_DATA;
                    end else if (ir_rx.crc_ok && ir_rx.kind == KIND_DISC
                        && ir_rx.slot == SLOT_RESP) begin
                        resp_d = RESP_DISC;
                    end else begin
                        state_d = ST_DISC;
                    end
                end else if (rx_take) begin
                    state_d = ST_RX;
                end
                if (conn_q && (idle_q == TO_LAST) && (state_q != ST_DISC)) begin
                    conn_d = 1'b0;
                    rate_d = RATE_DEFAULT;
                    state_d = ST_DISC;
                end
            end
            ST_TURN: begin
                // 1 ms is far above one bit time at any rate, so it covers the gap
                if (turn_q == '0) begin
                    state_d = ST_TX;
                    idx_d = '0;
                    len_d = '0;
                    if (conn_q && resp_q == RESP_DATA) begin
                        len_d = (ser_count > CW'(FRAME_PAYLOAD)) ?
                            7'(FRAME_PAYLOAD) : 7'(ser_count);
                    end
                end else begin
                    turn_d = turn_q - 1'b1;
                end
            end
            ST_TX: begin
                if (load) begin
                    txv_d = 1'b1;
                    idx_d = idx_q + 1'b1;
                    txb_d.sof = (idx_q == '0);
                    txb_d.eof = (idx_q == total - 1'b1);
                    if (ser_pop) begin
                        txb_d.data = ser_out_data;
                    end else if (idx_q == total - 1'b1) begin
                        txb_d.data = TRL_EOF;
                    end else if (idx_q == total - 7'd2) begin
                        txb_d.data = TRL_FCS;
                    end else begin
                        case (idx_q)
                            7'd0: txb_d.data = HDR_BOF;
                            7'd1: txb_d.data = LINK_ADDR;
                            7'd2: begin
                                txb_d.data = '0;
                                txb_d.data[CTL_ACK_BIT] = ack_q;
                                txb_d.data[CTL_CLOSE_BIT] = (resp_q == RESP_CLOSE);
                                txb_d.data[CTL_DISC_BIT] = (resp_q == RESP_DISC);
                            end
                            7'd3: txb_d.data = {1'b0, len_q};
                            7'd4: txb_d.data = {5'h00, rate_q};
                            default: txb_d.data = HDR_PAD;
                        endcase
                    end
                end else if ((idx_q == total) && !txv_q) begin
                    // last byte gone: only now may the receiver be opened again
                    state_d = ST_CONN;
                    if (!conn_q || resp_q != RESP_DATA) begin
                        conn_d = 1'b0;
                        rate_d = RATE_DEFAULT;
                        state_d = ST_DISC;
                    end
                end
            end
            default: state_d = ST_DISC;
        endcase
        if (!en_q) begin
            state_d = ST_DISC;
            conn_d = 1'b0;
            rate_d = RATE_DEFAULT;
            txv_d = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ST_DISC;
            resp_q <= RESP_DATA;
            conn_q <= 1'b0;
            ack_q <= 1'b0;
            txv_q <= 1'b0;
            txb_q <= '0;
            turn_q <= '0;
            idle_q <= '0;
            rate_q <= RATE_DEFAULT;
            len_q <= '0;
            idx_q <= '0;
            init_q <= '0;
            dsr_q <= 1'b0;
            irdiv_q <= '0;
            serdiv_q <= '0;
        end else begin
            state_q <= state_d;
            resp_q <= resp_d;
            conn_q <= conn_d;
            ack_q <= ack_d;
            txv_q <= txv_d;
            txb_q <= txb_d;
            turn_q <= turn_d;
            idle_q <= idle_d;
            rate_q <= rate_d;
            len_q <= len_d;
            idx_q <= idx_d;
            init_q <= init_d;
            dsr_q <= dsr_d;
            irdiv_q <= irsl_ir_div(rate_q);
            serdiv_q <= irsl_ser_div(serial_rate_select_pins);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: zero wait states, always OKAY, read data taken at address phase
    logic take, wr_q, wr_d, en_d;
    logic [7:0] addr_q, addr_d, drop_q, drop_d, crc_q, crc_d, nack_q, nack_d;
    logic [31:0] rdata_q, rdata_d, rmux;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;
    assign take = hsel && htrans[1] && hready;

    always_comb begin
        rmux = '0;
        case (haddr[7:0])
            REG_CTRL: rmux[CTRL_EN_BIT] = en_q;
            REG_STATUS: begin
                rmux[ST_CONN_BIT] = conn_q;
                rmux[ST_CTSN_BIT] = cts_n;
                rmux[ST_DSR_BIT] = dsr_q;
                rmux[ST_RATE_LSB +: 3] = rate_q;
                rmux[ST_STATE_LSB +: 3] = state_q;
            end
            REG_LEVEL: rmux = {16'h0000, 1'b0, ser_count, 1'b0, ir_count};
            REG_ERR: rmux = {8'h00, nack_q, crc_q, drop_q};
            default: rmux = '0;
        endcase
        wr_d = take && hwrite;
        addr_d = take ? haddr[7:0] : addr_q;
        rdata_d = (take && !hwrite) ? rmux : rdata_q;
        en_d = en_q;
        drop_d = drop_q;
        crc_d = crc_q;
        nack_d = nack_q;
        if (wr_q && addr_q == REG_CTRL) begin
            en_d = hwdata[CTRL_EN_BIT];
        end
        // any write to the error register clears it; a new event in that cycle wins
        if (wr_q && addr_q == REG_ERR) begin
            drop_d = '0;
            crc_d = '0;
            nack_d = '0;
        end
        if (drop_inc && drop_d != 8'hff) begin
            drop_d = drop_d + 1'b1;
        end
        if (crc_inc && crc_d != 8'hff) begin
            crc_d = crc_d + 1'b1;
        end
        if (nack_inc && nack_d != 8'hff) begin
            nack_d = nack_d + 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            addr_q <= '0;
            rdata_q <= '0;
            en_q <= CTRL_EN_RST;
            drop_q <= '0;
            crc_q <= '0;
            nack_q <= '0;
        end else begin
            wr_q <= wr_d;
            addr_q <= addr_d;
            rdata_q <= rdata_d;
            en_q <= en_d;
            drop_q <= drop_d;
            crc_q <= crc_d;
            nack_q <= nack_d;
        end
    end

endmodule : irsl_link
`default_nettype wire

// [bench/irsl_link_sva.sv]
// port assertions for the infrared secondary link block
`timescale 1ns/100ps
`default_nettype none
module irsl_link_sva
    import irsl_pkg::*;
#(
    parameter int unsigned TURN_CYCLES = TURN_CYC,
    parameter int unsigned TIMEOUT_CYCLES = LINK_TIMEOUT_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ir_rx_valid,
    input wire irsl_rx_t ir_rx,
    input wire logic ir_rx_ready,
    input wire logic ir_tx_valid,
    input wire irsl_tx_t ir_tx,
    input wire logic ir_tx_ready,
    input wire logic cts_n,
    input wire logic dsr,
    input wire logic carrier_detect
);
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic eof_in;
    logic [4:0] boot_q;
    logic [4:0] boot_d;
    logic [31:0] quiet_q;
    logic [31:0] quiet_d;
    always_comb begin
        eof_in = ir_rx_valid && ir_rx_ready && ir_rx.eof;
        boot_d = (boot_q == 5'h1f) ? boot_q : boot_q + 5'h1;
        quiet_d = eof_in ? 32'h0 : quiet_q + 32'h1;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            boot_q <= 5'h0;
            quiet_q <= 32'h0;
        end else begin
            boot_q <= boot_d;
            quiet_q <= quiet_d;
        end
    end
    sequence eof_conn;
        eof_in && carrier_detect;
    endsequence
    a_cts_offline: assert property (!carrier_detect && !$past(carrier_detect) |-> cts_n)
        else $error("cts active while link down");
    a_cts_ir_busy: assert property (ir_tx_valid || (ir_rx_valid && !ir_rx.sof) |-> cts_n)
        else $error("cts active during infrared frame");
    a_dsr_early: assert property (dsr |-> boot_q >= 5'd17)
        else $error("dsr before init done");
    a_dsr_late: assert property (boot_q == 5'd20 |-> dsr)
        else $error("dsr missing after init");
    a_tx_hold: assert property (ir_tx_valid && !ir_tx_ready |=> ir_tx_valid && $stable(ir_tx))
        else $error("tx byte dropped while stalled");
    // catches an answer that skips or shortens our own turnaround
    a_turn_gap: assert property ($rose(ir_tx_valid) |-> quiet_q >= TURN_CYCLES)
        else $error("answer inside turnaround");
    a_answer_due: assert property (eof_conn |-> ##[20:40] ir_tx_valid)
        else $error("frame left unanswered");
    a_close_drop: assert property (eof_conn ##0 (ir_rx.kind == KIND_CLOSE && ir_rx.crc_ok)
        |-> ##[20:300] !carrier_detect)
        else $error("close not honoured");
endmodule : irsl_link_sva
bind irsl_link irsl_link_sva #(.TURN_CYCLES(TURN_CYCLES), .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_sva (.*);
`default_nettype wire

// [bench/irsl_xcvr.sv]
// primary device behind its transceiver, facing the link block
`timescale 1ns/100ps
`default_nettype none
module irsl_xcvr
    import irsl_pkg::*;
(
    input wire logic hclk,
    input wire logic ir_rx_ready,
    input wire logic ir_tx_valid,
    input wire irsl_tx_t ir_tx,
    output logic ir_rx_valid,
    output irsl_rx_t ir_rx,
    output logic ir_tx_ready
);
    logic slow = 1'b0;
    logic [7:0] got[$];
    initial begin
        ir_rx_valid = 1'b0;
        ir_rx = '0;
        ir_tx_ready = 1'b1;
    end
    // slow mode drops ready on every other cycle
    always @(posedge hclk) begin
        if (ir_tx_valid && ir_tx_ready) got.push_back(ir_tx.data);
        ir_tx_ready <= !slow || !ir_tx_ready;
    end
    // one frame of n payload bytes, each beat held until taken
    task automatic send(input irsl_kind_t k, input logic ok, input int n);
        for (int i = 0; i <= n; i++) begin
            ir_rx_valid <= 1'b1;
            ir_rx <= '{i == 0, i == n, i < n, ok, 1'b1, k, SLOT_RESP, 8'(i + 8'h40)};
            do @(negedge hclk); while (!ir_rx_ready);
            @(posedge hclk);
        end
        ir_rx_valid <= 1'b0;
        ir_rx.data <= ~ir_rx.data; // released line, no stale byte
    endtask : send
endmodule : irsl_xcvr
`default_nettype wire

// [bench/tb.sv]
// self-checking bench for the infrared secondary link block
`timescale 1ns/100ps
`default_nettype none
module tb;
    import irsl_pkg::*;
    localparam int unsigned TURN = 20;
    localparam int unsigned TMO = 500;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, link_open;
    logic ir_rx_valid, ir_rx_ready, ir_tx_valid, ir_tx_ready, ser_in_valid;
    logic host_out_valid, cts_n, dsr, carrier_detect;
    logic host_out_ready = 1'b1;
    logic [2:0] hsize = 3'h2;
    logic [1:0] htrans, serial_rate_select_pins;
    logic [2:0] link_rate_sel;
    logic [7:0] ser_in_data, host_out_data;
    logic [15:0] ir_bit_div, serial_bit_div;
    logic [31:0] haddr, hwdata, hrdata, rd;
    irsl_rx_t ir_rx;
    irsl_tx_t ir_tx;
    int err_total = 0;
    int n_checks = 0;
    int n_host = 0;
    int sbaud[4] = '{9600, 19200, 57600, 115200};
    assign hready = hreadyout;
    irsl_link #(.TURN_CYCLES(TURN), .TIMEOUT_CYCLES(TMO)) dut (.*);
    irsl_xcvr xc (.*);
    // partner numbers its payload bytes from 8'h40 up within each frame
    always @(posedge hclk) begin
        if (host_out_valid && host_out_ready) begin
            check(host_out_data, 32'(n_host) + 32'h40);
            n_host++;
        end
    end
    ////////////////////////////////////////
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : check
    task automatic conclude();
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= 32'(a);
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (!hready);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (!hready);
        rd = hrdata;
    endtask : bus
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(rd, e);
    endtask : rchk
    // the primary stays silent until our answer has gone out
    task automatic frame(input irsl_kind_t k, input logic ok, input int n);
        xc.got.delete();
        xc.send(k, ok, n);
        repeat (TURN + 4) @(posedge hclk);
        while (ir_tx_valid) @(posedge hclk);
        @(posedge hclk);
    endtask : frame
    task automatic open_link(input logic [2:0] r);
        link_rate_sel <= r;
        link_open <= 1'b1;
        @(posedge hclk);
        link_open <= 1'b0;
        repeat (3) @(posedge hclk);
        @(negedge hclk);
    endtask : open_link
    ////////////////////////////////////////
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    initial begin
        #1_000_000;
        err_total++;
        conclude();
    end
    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        {link_open, link_rate_sel, ser_in_valid, ser_in_data, serial_rate_select_pins} = '0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (20) @(posedge hclk);
        rchk(REG_CTRL, 32'h1);
        rchk(REG_STATUS, 32'h6);
        rchk(8'h10, 32'h0);
        for (int i = 0; i < 4; i++) begin
            serial_rate_select_pins <= 2'(i);
            @(posedge hclk);
            @(negedge hclk);
            check(serial_bit_div, CLK_HZ / sbaud[i]);
            check(ir_bit_div, CLK_HZ / IR_DEFAULT_BAUD);
            @(posedge hclk);
        end
        open_link(3'h7);
        check(carrier_detect, 1'b1);
        check(ir_bit_div, CLK_HZ / IR_MAX_BAUD);
        check(cts_n, 1'b0);
        @(posedge hclk);
        // host overruns on purpose: buffer fills, fifo keeps two, rest lost
        for (int i = 0; i < 70; i++) begin
            ser_in_valid <= 1'b1;
            ser_in_data <= 8'(i);
            @(posedge hclk);
            ser_in_valid <= 1'b0;
            @(posedge hclk);
        end
        @(negedge hclk);
        check(cts_n, 1'b1);
        @(posedge hclk);
        rchk(REG_LEVEL, 32'h4000);
        rchk(REG_ERR, 32'h4);
        xc.slow = 1'b1;
        frame(KIND_DATA, 1'b1, 2);
        check(xc.got.size(), FRAME_TOTAL);
        check(xc.got[3], 32'd64);
        check(xc.got[2][0], 1'b1);
        check(n_host, 2);
        // fifo drains one byte a cycle once idle again
        @(posedge hclk);
        rchk(REG_LEVEL, 32'h200);
        xc.slow = 1'b0;
        frame(KIND_DATA, 1'b0, 0);
        check(xc.got.size(), FRAME_OVERHEAD + 2);
        check(xc.got[2][0], 1'b0);
        rchk(REG_ERR, 32'h104);
        bus(1'b1, REG_ERR, 32'h0);
        rchk(REG_ERR, 32'h0);
        frame(KIND_CLOSE, 1'b1, 0);
        check(xc.got[2][1], 1'b1);
        @(negedge hclk);
        check(carrier_detect, 1'b0);
        check(ir_bit_div, CLK_HZ / IR_DEFAULT_BAUD);
        @(posedge hclk);
        frame(KIND_DISC, 1'b1, 0);
        check(xc.got[2][2], 1'b1);
        check(carrier_detect, 1'b0);
        open_link(3'h2);
        repeat (TMO - 30) @(negedge hclk);
        check(carrier_detect, 1'b1);
        repeat (40) @(negedge hclk);
        check(carrier_detect, 1'b0);
        conclude();
    end
endmodule : tb
`default_nettype wire
